// File: rtl/iss_regs.svh
`ifndef ISS_REGS_SVH
`define ISS_REGS_SVH
// Delay from line sync to first valid pixel, in clocks
`define ISS_PIX_DELAY      4'd5
// Row blanking multiplier on the column granularity
`define ISS_BLANK_MULT     11'd35
// Stable time multiplier on the shutter granularity
`define ISS_STABLE_MULT    11'd5
// Least column and shutter granularities
`define ISS_COL_GRAN_BASE  11'd4
`define ISS_SH_GRAN_BASE   11'd32
// Clock period in ns and upload times in ns
`define ISS_CLK_NS         100
`define ISS_TPAR_NS        1000
`define ISS_TSER_NS        8000
`define ISS_TLOAD_PAR_NS   1000
`define ISS_TLOAD_SER_NS   16000
`define ISS_UPL_PAR_CYC    ((`ISS_TPAR_NS+`ISS_CLK_NS-1)/`ISS_CLK_NS)
`define ISS_UPL_SER_CYC    ((`ISS_TSER_NS+`ISS_CLK_NS-1)/`ISS_CLK_NS)
`define ISS_LOAD_PAR_CYC   ((`ISS_TLOAD_PAR_NS+`ISS_CLK_NS-1)/`ISS_CLK_NS)
`define ISS_LOAD_SER_CYC   ((`ISS_TLOAD_SER_NS+`ISS_CLK_NS-1)/`ISS_CLK_NS)
// Least reset and frame start widths in clocks
`define ISS_RESET_CYC      4'd5
`define ISS_FRAME_CYC      4'd3
// Number of reset levels, FIFO depth, counter widths
`define ISS_KNEE_STEPS     3'd4
`define ISS_FIFO_DEPTH     4
`define ISS_CW             11
`endif

// File: rtl/iss_pkg.sv
package iss_pkg;
   typedef logic [10:0] iss_cnt_t;
   typedef logic [1:0]  iss_gran_t;
   typedef enum logic [3:0]
   {
      SQ_IDLE  = 4'h1,
      SQ_BLANK = 4'h2,
      SQ_DELAY = 4'h4,
      SQ_PIX   = 4'h8
   } iss_line_t;
   function automatic iss_cnt_t iss_scale(iss_cnt_t base, iss_gran_t g,
                                          iss_cnt_t mult);
      iss_cnt_t s;
      s = base << g;
      return 11'(s * mult);
   endfunction
endpackage

// File: rtl/iss_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface iss_link_if;
   logic        sysReset;
   logic        frameStart;
   logic        lineClock;
   logic        xLoad;
   logic        shutterStart;
   logic        shutterStop;
   logic        rollingMode;
   logic [1:0]  columnSeqGranularity;
   logic [1:0]  shutterSeqGranularity;
   logic [1:0]  resetLevelSelect;
   logic        resetLevelEnable;
   logic [10:0] xPointer;
   logic [10:0] resetRowPointer;
   logic [10:0] readRowPointer;
   logic [10:0] lineCountSetting;
   logic [10:0] pixelCountSetting;
   logic [10:0] intTime;
   logic        pixelValid;
   logic        timeOut;
   logic        lastLine;
   logic        pixelOutValid;
   logic [10:0] analogPixelOutput;
   modport sensor (input sysReset, frameStart, lineClock, xLoad,
      shutterStart, shutterStop, rollingMode, columnSeqGranularity,
      shutterSeqGranularity, resetLevelSelect, resetLevelEnable,
      xPointer, resetRowPointer, readRowPointer, lineCountSetting,
      pixelCountSetting, intTime,
      output pixelValid, timeOut, lastLine, pixelOutValid,
      analogPixelOutput);
   modport ctrl (output sysReset, frameStart, lineClock, xLoad,
      shutterStart, shutterStop, rollingMode, columnSeqGranularity,
      shutterSeqGranularity, resetLevelSelect, resetLevelEnable,
      xPointer, resetRowPointer, readRowPointer, lineCountSetting,
      pixelCountSetting, intTime,
      input pixelValid, timeOut, lastLine, pixelOutValid,
      analogPixelOutput);
endinterface
`default_nettype wire

// File: rtl/iss_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module iss_fifo
#(
   parameter int WIDTH = 11,
   parameter int DEPTH = 4
)
(
   input  wire logic             mclk,
   input  wire logic             rst_b,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr_q;
   logic [AW-1:0]    rdPtr_q;
   logic [AW:0]      count_q;
   logic             push;
   logic             pop;

   assign inReady  = (count_q != (AW+1)'(DEPTH));
   assign outValid = (count_q != '0);
   assign outData  = mem[rdPtr_q];
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;

   always_ff @(posedge mclk)
   begin
      if (push)
         mem[wrPtr_q] <= inData;
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end
      else
      begin
         if (push)
            wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
         if (pop)
            rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
         count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // iss_fifo
`default_nettype wire

// File: rtl/iss_sensor.sv
`timescale 1ns/10ps
`default_nettype none
`include "iss_regs.svh"
module iss_sensor
   import iss_pkg::*;
(
   input  wire logic mclk,
   input  wire logic rst_b,
   iss_link_if.sensor lnk,
   output logic      calibrate,
   output logic [10:0] readRowShift,
   output logic [10:0] resetRowShift,
   output logic [2:0]  resetLevel
);
   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers: inputs arrive from another chip
   logic [1:0] rstS_q, fsS_q, lcS_q, xlS_q, ssaS_q, ssoS_q;
   logic       gRst, fs, lc, xl, ssa, sso;
   logic       fsD_q, lcD_q, xlD_q, ssaD_q;
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rstS_q <= '0;
         fsS_q  <= '0;
         lcS_q  <= '0;
         xlS_q  <= '0;
         ssaS_q <= '0;
         ssoS_q <= '0;
         fsD_q  <= 1'b0;
         lcD_q  <= 1'b0;
         xlD_q  <= 1'b0;
         ssaD_q <= 1'b0;
      end
      else
      begin
         rstS_q <= {rstS_q[0], lnk.sysReset};
         fsS_q  <= {fsS_q[0], lnk.frameStart};
         lcS_q  <= {lcS_q[0], lnk.lineClock};
         xlS_q  <= {xlS_q[0], lnk.xLoad};
         ssaS_q <= {ssaS_q[0], lnk.shutterStart};
         ssoS_q <= {ssoS_q[0], lnk.shutterStop};
         fsD_q  <= fsS_q[1];
         lcD_q  <= lcS_q[1];
         xlD_q  <= xlS_q[1];
         ssaD_q <= ssaS_q[1];
      end
   end
   assign gRst = rstS_q[1];
   // Edges for all but system reset and shutter stop, which act as levels; a pulse held two edges still acts once
   assign fs  = fsS_q[1] && !fsD_q;
   assign lc  = lcS_q[1] && !lcD_q;
   assign xl  = xlS_q[1] && !xlD_q;
   assign ssa = ssaS_q[1] && !ssaD_q;
   assign sso = ssoS_q[1];

   ////////////////////////////////////////////////////////////////////
   // Line sequencer
   iss_line_t  st_q;
   iss_cnt_t   cnt_q;
   iss_cnt_t   pix_q;
   iss_cnt_t   xShift_q;
   logic       pv_q;
   logic       dat_q;
   iss_cnt_t   blankLen;
   assign blankLen = iss_scale(`ISS_COL_GRAN_BASE, lnk.columnSeqGranularity,
                               `ISS_BLANK_MULT);

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_q     <= SQ_IDLE;
         cnt_q    <= '0;
         pix_q    <= '0;
         xShift_q <= '0;
         pv_q     <= 1'b0;
         dat_q    <= 1'b0;
      end
      else if (gRst)
      begin
         st_q     <= SQ_IDLE;
         cnt_q    <= '0;
         pix_q    <= '0;
         xShift_q <= '0;
         pv_q     <= 1'b0;
         dat_q    <= 1'b0;
      end
      else if (xl)
      begin
         // Forced sync replaces the internal one
         xShift_q <= lnk.xPointer;
         st_q     <= SQ_DELAY;
         cnt_q    <= '0;
         pix_q    <= '0;
         pv_q     <= 1'b1;
         dat_q    <= 1'b0;
      end
      else
      begin
         case (st_q)
            SQ_IDLE:
            begin
               dat_q <= 1'b0;
               pv_q  <= 1'b0;
               if (lc)
               begin
                  st_q  <= SQ_BLANK;
                  cnt_q <= '0;
               end
            end
            SQ_BLANK:
            begin
               if (cnt_q == blankLen - 11'd1)
               begin
                  st_q     <= SQ_DELAY;
                  cnt_q    <= '0;
                  pv_q     <= 1'b1;
                  xShift_q <= '0;
               end
               else
                  cnt_q <= cnt_q + 11'd1;
            end
            SQ_DELAY:
            begin
               // The FIFO stage supplies the last clock of the delay
               if (cnt_q == 11'(`ISS_PIX_DELAY) - 11'd2)
               begin
                  st_q  <= SQ_PIX;
                  dat_q <= 1'b1;
               end
               else
                  cnt_q <= cnt_q + 11'd1;
            end
            SQ_PIX:
            begin
               xShift_q <= xShift_q + 11'd1;
               if (pix_q == lnk.pixelCountSetting - 11'd1)
               begin
                  // Valid drops one clock later, with the last pixel out
                  st_q  <= SQ_IDLE;
               end
               else
                  pix_q <= pix_q + 11'd1;
            end
            default: st_q <= SQ_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Frame, rows and integration
   iss_cnt_t lineNo_q, intCnt_q;
   logic     to_q, ll_q, cal_q, armed_q;
   logic [2:0] lvl_q;
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         lineNo_q <= '0;
         intCnt_q <= '0;
         to_q     <= 1'b0;
         ll_q     <= 1'b0;
         cal_q    <= 1'b0;
         armed_q  <= 1'b0;
         lvl_q    <= '0;
         readRowShift  <= '0;
         resetRowShift <= '0;
      end
      else if (gRst)
      begin
         lineNo_q <= '0;
         intCnt_q <= '0;
         to_q     <= 1'b0;
         ll_q     <= 1'b0;
         cal_q    <= 1'b0;
         armed_q  <= 1'b0;
         lvl_q    <= '0;
         readRowShift  <= '0;
         resetRowShift <= '0;
      end
      else
      begin
         to_q  <= 1'b0;
         cal_q <= fs;
         if (fs)
         begin
            readRowShift <= lnk.readRowPointer;
            lineNo_q     <= '0;
            armed_q      <= lnk.rollingMode;
            ll_q         <= 1'b0;
         end
         else if (lc)
         begin
            lineNo_q <= lineNo_q + 11'd1;
            ll_q <= (lineNo_q + 11'd1 == lnk.lineCountSetting);
            readRowShift <= readRowShift + 11'd1;
            resetRowShift <= resetRowShift + 11'd1;
            // Reset row sync after intTime lines, in rolling mode only
            if (armed_q && (lineNo_q + 11'd1 == lnk.intTime))
            begin
               resetRowShift <= lnk.resetRowPointer;
               to_q    <= 1'b1;
               armed_q <= 1'b0;
            end
         end
         if (ssa)
         begin
            intCnt_q <= '0;
            // Level 0 is the normal reset; 1..4 are lower ones
            lvl_q <= lnk.resetLevelEnable ?
                     {1'b0, lnk.resetLevelSelect} + 3'd1 : 3'd0;
         end
         else if (!sso && !lnk.rollingMode)
            intCnt_q <= intCnt_q + 11'd1;
         if (!lnk.rollingMode && !ssa && intCnt_q == lnk.intTime
             && intCnt_q != '0)
            to_q <= 1'b1;
      end
   end
   assign calibrate  = cal_q;
   assign resetLevel = lvl_q;

   ////////////////////////////////////////////////////////////////////
   // Pixel data path through the FIFO; outReady is tied high, so the sink never stalls it
   logic fifoReady;
   iss_fifo #(.WIDTH(11), .DEPTH(`ISS_FIFO_DEPTH)) u_fifo
   (
      .mclk     (mclk),
      .rst_b    (rst_b),
      .inValid  (dat_q && st_q == SQ_PIX),
      .inReady  (fifoReady),
      .inData   (xShift_q),
      .outValid (lnk.pixelOutValid),
      .outReady (1'b1),
      .outData  (lnk.analogPixelOutput)
   );
   assign lnk.pixelValid = pv_q;
   assign lnk.timeOut    = to_q;
   assign lnk.lastLine   = ll_q;
endmodule // iss_sensor
`default_nettype wire

// File: rtl/iss_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "iss_regs.svh"
module iss_ctrl
   import iss_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst_b,
   iss_link_if.ctrl         lnk,
   input  wire logic        startFrame,
   input  wire logic        startLine,
   input  wire logic        loadX,
   input  wire logic [10:0] newX,
   output logic             busy
);
   logic [3:0] rstCnt_q;
   logic [3:0] fsCnt_q;
   logic [1:0] xlCnt_q;
   logic       lc_q;
   always_ff @(negedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rstCnt_q <= `ISS_RESET_CYC;
         fsCnt_q  <= '0;
         xlCnt_q  <= '0;
         lc_q     <= 1'b0;
      end
      else
      begin
         if (rstCnt_q != '0)
            rstCnt_q <= rstCnt_q - 4'd1;
         lc_q <= startLine && rstCnt_q == '0;
         if (startFrame && rstCnt_q == '0)
            fsCnt_q <= `ISS_FRAME_CYC;
         else if (fsCnt_q != '0)
            fsCnt_q <= fsCnt_q - 4'd1;
         if (loadX && rstCnt_q == '0)
            xlCnt_q <= 2'd2;
         else if (xlCnt_q != '0)
            xlCnt_q <= xlCnt_q - 2'd1;
      end
   end
   assign lnk.sysReset  = rstCnt_q != '0;
   assign lnk.frameStart = fsCnt_q != '0;
   assign lnk.lineClock  = lc_q;
   assign lnk.xLoad      = xlCnt_q != '0;
   assign lnk.xPointer   = newX;
   // Static defaults; multi-slope sequencing is left idle
   assign lnk.shutterStart = 1'b0;
   assign lnk.shutterStop  = 1'b0;
   assign lnk.rollingMode  = 1'b1;
   assign lnk.columnSeqGranularity  = 2'b00;
   assign lnk.shutterSeqGranularity = 2'b00;
   assign lnk.resetLevelSelect = 2'b00;
   assign lnk.resetLevelEnable = 1'b0;
   // Equal row pointers for normal rolling operation
   assign lnk.resetRowPointer  = 11'h020;
   assign lnk.readRowPointer   = 11'h020;
   assign lnk.lineCountSetting = 11'h002;
   assign lnk.pixelCountSetting = 11'h500;
   assign lnk.intTime = 11'h001;
   assign busy = lnk.sysReset || lnk.frameStart || lnk.xLoad;
endmodule // iss_ctrl
`default_nettype wire

// File: verification/iss_link_chk.sv
`timescale 1ns/10ps
`default_nettype none
module iss_link_chk
(
   input wire logic       mclk,
   input wire logic       rst_b,
   input wire logic       sysReset,
   input wire logic       frameStart,
   input wire logic       lineClock,
   input wire logic       xLoad,
   input wire logic       shutterStart,
   input wire logic       shutterStop,
   input wire logic [1:0] columnSeqGranularity,
   input wire logic [1:0] resetLevelSelect,
   input wire logic       resetLevelEnable,
   input wire logic       pixelValid,
   input wire logic       timeOut,
   input wire logic       pixelOutValid
);
   int   blankCnt_q;
   logic armed_q;
   int   blankMin;
   int   rstLen_q;
   // Sync flops add a few clocks on top of the blanking itself
   assign blankMin = 35 * (4 << columnSeqGranularity);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk or negedge rst_b)
      if (!rst_b)
         blankCnt_q <= 0;
      else if ($rose(lineClock))
         blankCnt_q <= 0;
      else
         blankCnt_q <= blankCnt_q + 1;
   // Reset is high from power-on, so its length is counted, not its rise
   always_ff @(posedge mclk or negedge rst_b)
      if (!rst_b)
         rstLen_q <= 0;
      else if (sysReset)
         rstLen_q <= rstLen_q + 1;
      else
         rstLen_q <= 0;
   // An X load restarts the line without blanking, so it disarms
   always_ff @(posedge mclk or negedge rst_b)
      if (!rst_b)
         armed_q <= 1'b0;
      else if ($rose(lineClock))
         armed_q <= 1'b1;
      else if (xLoad || $rose(pixelValid))
         armed_q <= 1'b0;
   ////////////////////////////////////////////////////////////////////////
   a_pixel_delay: assert property ($rose(pixelValid) |-> ##5 pixelOutValid)
      else $error("pixel data not valid five clocks after line sync");
   a_row_blank: assert property (armed_q && $rose(pixelValid) |->
      blankCnt_q >= blankMin && blankCnt_q <= blankMin + 6)
      else $error("row blanking length wrong");
   a_timeout_pulse: assert property (timeOut |=> !timeOut)
      else $error("timeout longer than one clock");
   a_reset_width: assert property ($fell(sysReset) |-> rstLen_q >= 5)
      else $error("global reset shorter than five clocks");
   a_ctl_low: assert property (sysReset |-> !frameStart && !lineClock
      && !xLoad && !shutterStart && !shutterStop)
      else $error("control input high during global reset");
   a_frame_width: assert property ($rose(frameStart) |-> frameStart[*3])
      else $error("frame start shorter than three clocks");
   a_xload_two: assert property ($rose(xLoad) |-> xLoad[*2])
      else $error("x load not held over two edges");
   a_level_stop: assert property (shutterStop |->
      resetLevelSelect == 2'h0 && !resetLevelEnable)
      else $error("reset level not cleared at shutter stop");
   cover property ($rose(pixelValid));
   cover property ($rose(xLoad));
   cover property ($rose(frameStart));
   cover property ($rose(timeOut));
endmodule // iss_link_chk
`default_nettype wire

// File: verification/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic        mclk = 1'b0;
   logic        rst_b, startFrame, startLine, loadX, busy, calibrate;
   logic [10:0] newX, readRowShift, resetRowShift, firstPix, lastPix;
   logic [2:0]  resetLevel;
   int          errors, nChecks, cyc, calibCnt, tLine, tPv, tOut, pvLen;
   int          xLen, c0, d, outLen, toCnt;
   iss_link_if lnk ();
   always #50 mclk = ~mclk;
   ////////////////////////////////////////////////////////////////////////
   iss_sensor iss_sensor_inst (.mclk(mclk), .rst_b(rst_b), .lnk(lnk),
      .calibrate(calibrate), .readRowShift(readRowShift),
      .resetRowShift(resetRowShift), .resetLevel(resetLevel));
   iss_ctrl iss_ctrl_inst (.mclk(mclk), .rst_b(rst_b), .lnk(lnk),
      .startFrame(startFrame), .startLine(startLine), .loadX(loadX),
      .newX(newX), .busy(busy));
   iss_link_chk iss_link_chk_inst (.mclk(mclk), .rst_b(rst_b),
      .sysReset(lnk.sysReset), .frameStart(lnk.frameStart),
      .lineClock(lnk.lineClock), .xLoad(lnk.xLoad),
      .shutterStart(lnk.shutterStart), .shutterStop(lnk.shutterStop),
      .columnSeqGranularity(lnk.columnSeqGranularity),
      .resetLevelSelect(lnk.resetLevelSelect),
      .resetLevelEnable(lnk.resetLevelEnable),
      .pixelValid(lnk.pixelValid), .timeOut(lnk.timeOut),
      .pixelOutValid(lnk.pixelOutValid));
   ////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("checks %0d errors %0d", nChecks, errors);
      if (errors == 0 && nChecks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      nChecks++;
      if (seen !== exp)
      begin
         errors++;
         $display("ERROR %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   // Wait out the whole line, FIFO tail included
   task automatic pulse(input int k);
      int n;
      n = 0;
      // The controller samples on this same edge, hence non-blocking
      startFrame <= (k == 0);
      startLine  <= (k == 1);
      loadX      <= (k == 2);
      @(negedge mclk);
      startFrame <= 1'b0;
      startLine  <= 1'b0;
      loadX      <= 1'b0;
      // Blanking alone is 140 clocks; let the line start first
      repeat (160) @(negedge mclk);
      while ((busy !== 1'b0 || lnk.pixelValid !== 1'b0
              || lnk.pixelOutValid !== 1'b0) && n < 6000)
      begin
         @(negedge mclk);
         n++;
      end
      check("idle", n < 6000, 1);
   endtask
   ////////////////////////////////////////////////////////////////////////
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (calibrate === 1'b1)
         calibCnt <= calibCnt + 1;
      if ($rose(lnk.lineClock))
         tLine <= cyc;
      if ($rose(lnk.pixelValid))
         tPv <= cyc;
      if ($rose(lnk.pixelOutValid))
      begin
         tOut     <= cyc;
         firstPix <= lnk.analogPixelOutput;
      end
      if (lnk.pixelOutValid === 1'b1)
         lastPix <= lnk.analogPixelOutput;
      outLen <= $rose(lnk.pixelOutValid) ? 1
                : outLen + (lnk.pixelOutValid === 1'b1);
      if (lnk.timeOut === 1'b1)
         toCnt <= toCnt + 1;
      pvLen <= $rose(lnk.pixelValid) ? 1 : pvLen + (lnk.pixelValid === 1'b1);
      xLen <= $rose(lnk.xLoad) ? 1 : xLen + (lnk.xLoad === 1'b1);
      // Whole run needs well under this many clocks
      if (cyc == 40000)
      begin
         errors++;
         print_verdict();
      end
   end
   initial
   begin
      {errors, nChecks, cyc, calibCnt, tLine, tPv, tOut, pvLen, xLen} = '0;
      {outLen, toCnt, firstPix, lastPix} = '0;
      {rst_b, startFrame, startLine, loadX} = '0;
      newX = 11'h000;
      repeat (20) @(negedge mclk);
      check("resetLevel", resetLevel, 0);
      check("readRowShift", readRowShift, 0);
      check("resetRowShift", resetRowShift, 0);
      rst_b <= 1'b1;
      repeat (30) @(negedge mclk);
      $display("TEST reset done");
      c0 = calibCnt;
      pulse(0);
      check("calibrate", calibCnt - c0, 1);
      check("readRowShift", readRowShift, 11'h020);
      $display("TEST frame done");
      pulse(1);
      check("pixelDelay", tOut - tPv, 5);
      d = tPv - tLine - 140;
      check("rowBlank", d >= 0 && d <= 6, 1);
      check("pixelValidLen", pvLen, 1280 + 5);
      check("pixelCount", outLen, 1280);
      check("firstPixel", firstPix, 11'h000);
      check("lastPixel", lastPix, 11'h4FF);
      check("outIdle", lnk.pixelOutValid, 0);
      check("timeOutCnt", toCnt, 1);
      check("resetRowShift", resetRowShift, 11'h020);
      check("readRowNext", readRowShift, 11'h021);
      check("lastLine", lnk.lastLine, 0);
      $display("TEST line done");
      pulse(1);
      check("lastLineSet", lnk.lastLine, 1);
      check("resetRowNext", resetRowShift, 11'h021);
      check("timeOutOnce", toCnt, 1);
      $display("TEST rows done");
      c0 = tPv;
      newX = 11'h0A2;
      pulse(2);
      check("xPointer", lnk.xPointer, 11'h0A2);
      check("xRestart", tPv > c0, 1);
      check("xLoadLen", xLen, 2);
      check("xFirstPixel", firstPix, 11'h0A2);
      check("xLastPixel", lastPix, 11'h5A1);
      check("xPixelCount", outLen, 1280);
      check("xPixelValidLen", pvLen, 1280 + 5);
      check("xDelay", tOut - tPv, 5);
      $display("TEST xload done");
      print_verdict();
   end
endmodule // tb
`default_nettype wire
